// *** rtl/wdrt_pkg.sv ***
// package: register map, field layout, reset values and timing counts of the watchdog reset timer
package wdrt_pkg;

   // apb data and address widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 12;

   // control register index as printed, byte address is four times it
   localparam logic [ADDR_W-1:0] CTRL_INDEX = 12'h0E1;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_INDEX[ADDR_W-3:0], 2'h0};

   // field positions inside the control register
   localparam int ENABLE_POS = 7;
   localparam int RESTART_POS = 6;
   localparam int PSEL_HI_POS = 2;
   localparam int PSEL_LO_POS = 0;
   localparam int PSEL_W = 3;

   // reset values of the implemented fields
   localparam logic ENABLE_RST = 1'b0;
   localparam logic RESTART_RST = 1'b0;
   localparam logic [PSEL_W-1:0] PSEL_RST = 3'h0;

   // interval for period select code zero, in base units
   localparam logic [3:0] UNITS_FOR_ZERO = 4'h8;

   // timing: reference clock and crystal figures
   localparam real REF_CLK_MHZ = 100.0;
   localparam real XTAL_MHZ = 24.0;
   localparam real BASE_UNIT_S = 0.107;

   // prescaler divides crystal ticks by this figure
   localparam int PRESCALE_DIV = 10000;
   // prescaler outputs that form one base unit
   localparam int UNIT_TICKS = 256;
   // width of the chip reset pulse, in ns, and its cycle count
   localparam real RESET_PULSE_NS = 160.0;
   localparam int RESET_PULSE_CYCLES = int'(RESET_PULSE_NS * REF_CLK_MHZ / 1000.0);

   // control register fields as carried inside the block
   typedef struct packed {
      logic enable;
      logic [PSEL_W-1:0] period_sel;
   } wdrt_ctrl_t;

endpackage

// *** rtl/wdrt_top.sv ***
// watchdog reset timer: apb control register, prescaler on synchronised crystal ticks, counter and chip reset
//
// How it works
// - enabled timer reaching interval resets chip
// - enable bit seven starts, stops counting
// - restart bit six clears counter, prescaler
// - counting runs from crystal clock ticks
// - select codes one to seven give N units
// - select code zero gives eight units
// - only select field chooses the interval
// - one register at index E1 controls
// - register readable, writable; unused bits zero
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module wdrt_top #(
   parameter int PRESCALE_DIV = wdrt_pkg::PRESCALE_DIV,
   parameter int UNIT_TICKS = wdrt_pkg::UNIT_TICKS
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // crystal clock pin, sampled as a plain input
   input wire logic crystal_clock_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [wdrt_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [wdrt_pkg::DATA_W-1:0] pwdata_in,
   output logic [wdrt_pkg::DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // chip reset request
   output logic chip_reset_out
);

   // counter widths
   localparam int PRE_W = $clog2(PRESCALE_DIV + 1);
   localparam int UNIT_W = $clog2(UNIT_TICKS + 1);
   localparam int PULSE_W = $clog2(wdrt_pkg::RESET_PULSE_CYCLES + 1);
   // last values of the prescaler and unit counters and the pulse load value, sized to the counters
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE_DIV - 1);
   localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_TICKS - 1);
   localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(wdrt_pkg::RESET_PULSE_CYCLES);

   // control fields held by software
   wdrt_pkg::wdrt_ctrl_t ctrl;
   // crystal pin synchroniser stages and edge history
   logic xtal_meta;
   logic xtal_sync;
   logic xtal_prev;
   // one-cycle pulse per crystal rising edge
   logic xtal_tick;
   // prescaler, unit tick count and base unit count
   logic [PRE_W-1:0] pre_cnt;
   logic [UNIT_W-1:0] tick_cnt;
   logic [3:0] unit_cnt;
   // interval target in base units
   logic [3:0] target_units;
   // decoded bus events
   logic bus_setup;
   logic bus_access;
   logic addr_hit;
   logic ctrl_write;
   logic restart_pulse;
   // timer events
   logic pre_wrap;
   logic unit_wrap;
   logic timeout;
   // reset pulse stretcher
   logic [PULSE_W-1:0] pulse_cnt;

   // apb phase decode
   assign bus_setup = psel_in && !penable_in;
   assign bus_access = psel_in && penable_in && pready_out;
   // only the one control word is mapped
   assign addr_hit = (paddr_in == wdrt_pkg::CTRL_ADDR);
   // a write takes effect at the access edge
   assign ctrl_write = bus_access && pwrite_in && addr_hit;
   // restart is a write of one to bit six
   assign restart_pulse = ctrl_write && pwdata_in[wdrt_pkg::RESTART_POS];

   // two-stage synchroniser for the crystal pin
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         xtal_meta <= 1'b0;
         xtal_sync <= 1'b0;
      end else begin
         xtal_meta <= crystal_clock_in;
         xtal_sync <= xtal_meta;
      end
   end

   // edge history of the synchronised crystal level
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         xtal_prev <= 1'b0;
      end else begin
         xtal_prev <= xtal_sync;
      end
   end

   // crystal rising edge becomes the counting enable
   assign xtal_tick = xtal_sync && !xtal_prev;

   // period select decode, code zero means eight units
   always_comb begin
      if (ctrl.period_sel == 3'h0) begin
         target_units = wdrt_pkg::UNITS_FOR_ZERO;
      end else begin
         target_units = {1'b0, ctrl.period_sel};
      end
   end

   // wrap points of prescaler and unit counter
   assign pre_wrap = ctrl.enable && xtal_tick && (pre_cnt == PRE_LAST);
   assign unit_wrap = pre_wrap && (tick_cnt == UNIT_LAST);
   // overflow once the unit count reaches the interval
   assign timeout = unit_wrap && ((unit_cnt + 4'h1) >= target_units) && !restart_pulse;

   // control register: write from bus, cleared by a watchdog timeout
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl.enable <= wdrt_pkg::ENABLE_RST;
         ctrl.period_sel <= wdrt_pkg::PSEL_RST;
      end else if (timeout) begin
         // timeout returns fields to reset values
         ctrl.enable <= wdrt_pkg::ENABLE_RST;
         ctrl.period_sel <= wdrt_pkg::PSEL_RST;
      end else if (ctrl_write) begin
         // store enable and period select
         ctrl.enable <= pwdata_in[wdrt_pkg::ENABLE_POS];
         ctrl.period_sel <= pwdata_in[wdrt_pkg::PSEL_HI_POS:wdrt_pkg::PSEL_LO_POS];
      end
   end

   // divide-by prescaler on crystal ticks
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pre_cnt <= '0;
      end else if (restart_pulse || timeout) begin
         // restart clears the prescaler
         pre_cnt <= '0;
      end else if (ctrl.enable && xtal_tick) begin
         // count only while enabled, hold otherwise
         if (pre_cnt == PRE_LAST) begin
            pre_cnt <= '0;
         end else begin
            pre_cnt <= pre_cnt + PRE_W'(1);
         end
      end
   end

   // prescaler outputs within one base unit
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_cnt <= '0;
      end else if (restart_pulse || timeout) begin
         // part of the programmable counter, cleared too
         tick_cnt <= '0;
      end else if (pre_wrap) begin
         if (tick_cnt == UNIT_LAST) begin
            tick_cnt <= '0;
         end else begin
            tick_cnt <= tick_cnt + UNIT_W'(1);
         end
      end
   end

   // base units elapsed since the last restart
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         unit_cnt <= 4'h0;
      end else if (restart_pulse || timeout) begin
         // software service keeps the count below the interval
         unit_cnt <= 4'h0;
      end else if (unit_wrap) begin
         unit_cnt <= unit_cnt + 4'h1;
      end
   end

   // stretch the timeout into a chip reset pulse
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pulse_cnt <= '0;
         chip_reset_out <= 1'b0;
      end else if (timeout) begin
         // start a fresh pulse
         pulse_cnt <= PULSE_LOAD;
         chip_reset_out <= 1'b1;
      end else if (pulse_cnt != '0) begin
         // hold until the count runs out
         pulse_cnt <= pulse_cnt - PULSE_W'(1);
         chip_reset_out <= (pulse_cnt != PULSE_W'(1));
      end else begin
         chip_reset_out <= 1'b0;
      end
   end

   // apb ready: one wait-free access cycle after each setup
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pready_out <= 1'b0;
      end else begin
         pready_out <= bus_setup;
      end
   end

   // apb error: unmapped address answers with slave error
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pslverr_out <= 1'b0;
      end else if (bus_setup) begin
         pslverr_out <= (paddr_in != wdrt_pkg::CTRL_ADDR);
      end else begin
         pslverr_out <= 1'b0;
      end
   end

   // apb read data: captured in setup, valid in access
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prdata_out <= '0;
      end else if (bus_setup && !pwrite_in && addr_hit) begin
         // restart reads zero, bits five to three read zero
         prdata_out <= '0;
         prdata_out[wdrt_pkg::ENABLE_POS] <= ctrl.enable;
         prdata_out[wdrt_pkg::PSEL_HI_POS:wdrt_pkg::PSEL_LO_POS] <= ctrl.period_sel;
      end else if (bus_setup) begin
         // writes and unmapped reads return zero
         prdata_out <= '0;
      end
   end

endmodule

// *** testbench/wdrt_properties.sv ***
// checker: port-level properties of the watchdog reset timer
`timescale 1ns/1ps
module wdrt_properties (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [wdrt_pkg::ADDR_W-1:0] paddr_in,
   input wire logic [wdrt_pkg::DATA_W-1:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // chip reset
   input wire logic chip_reset_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   int hi_cnt; // cycles the chip reset has stood high
   // pulse length counter
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) hi_cnt <= 0;
      else hi_cnt <= chip_reset_out ? hi_cnt + 1 : 0;
   end
   property p_rdy; psel_in && !penable_in |=> pready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_rdy1; pready_out |=> !pready_out; endproperty
   a_rdy1: assert property (p_rdy1) else $error("ready too long");
   property p_err; pslverr_out |-> pready_out; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_map;
      psel_in && !penable_in |=> pslverr_out == ($past(paddr_in) != wdrt_pkg::CTRL_ADDR);
   endproperty
   a_map: assert property (p_map) else $error("error flag wrong");
   property p_unm; pready_out && pslverr_out && !pwrite_in |-> prdata_out == 0; endproperty
   a_unm: assert property (p_unm) else $error("unmapped data");
   property p_unused;
      pready_out && !pslverr_out && !pwrite_in |-> prdata_out[31:8] == 0 && prdata_out[6:3] == 0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits set");
   property p_len; $fell(chip_reset_out) && hi_cnt != 0 |-> hi_cnt == wdrt_pkg::RESET_PULSE_CYCLES; endproperty
   a_len: assert property (p_len) else $error("reset pulse length");
   property p_cap; hi_cnt <= wdrt_pkg::RESET_PULSE_CYCLES; endproperty
   a_cap: assert property (p_cap) else $error("reset pulse too long");
endmodule
bind wdrt_top wdrt_properties u_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .chip_reset_out(chip_reset_out));

// *** testbench/watchdog_reset_timer_bench.sv ***
// self-checking bench of the watchdog reset timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin error_cnt++; \
   $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module watchdog_reset_timer_bench;
   localparam int PD = 2; // shortened prescaler
   localparam int UT = 2; // shortened unit
   localparam logic [11:0] CA = wdrt_pkg::CTRL_ADDR;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, crystal_clock_in = 1'b0;
   logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   logic pready_out, pslverr_out, chip_reset_out, er;
   logic run = 1'b0, seen = 1'b0; // crystal running, reset pulse seen
   int error_cnt = 0, compares = 0, xdiv = 0, ticks = 0, n;
   always #5 ref_clk_in = ~ref_clk_in;
   wdrt_top #(.PRESCALE_DIV(PD), .UNIT_TICKS(UT)) dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .crystal_clock_in(crystal_clock_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .chip_reset_out(chip_reset_out));
   // crystal at an eighth of the clock rate, still while stopped; counts rising edges
   always @(posedge ref_clk_in) begin
      if (chip_reset_out === 1'b1) seen <= 1'b1;
      if (run) begin
         xdiv <= (xdiv + 1) % 4;
         if (xdiv == 3) begin
            crystal_clock_in <= ~crystal_clock_in;
            if (!crystal_clock_in) ticks <= ticks + 1;
         end
      end
   end
   // one apb transfer, waits for ready
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
      int w;
      @(posedge ref_clk_in);
      psel_in <= 1'b1; pwrite_in <= wr; paddr_in <= ad; pwdata_in <= wd;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      w = 0;
      do begin @(posedge ref_clk_in); w++; end while (pready_out !== 1'b1 && w < 20);
      // no answer within the limit counts as a mismatch
      if (pready_out !== 1'b1) error_cnt++;
      rd = prdata_out; er = pslverr_out;
      psel_in <= 1'b0; penable_in <= 1'b0;
   endtask
   // stop crystal, write, restart tick count
   task automatic arm(input logic [31:0] wd);
      run <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      ticks <= 0; seen <= 1'b0;
      apb(1'b1, CA, wd);
      run <= 1'b1;
   endtask
   // wait until the crystal has ticked t times
   task automatic till(input int t);
      n = 0;
      while (ticks < t && n < 5000) begin
         @(posedge ref_clk_in);
         n++;
      end
      // crystal never got there in time
      if (ticks < t) error_cnt++;
   endtask
   task automatic give_verdict;
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // hang guard
   initial begin
      #500000;
      error_cnt++;
      give_verdict();
   end
   // main sequence
   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, CA, 32'h0);
      `CHK("reset value", 32'h0, rd)
      apb(1'b1, CA, 32'hFFFFFFFF);
      apb(1'b0, CA, 32'h0);
      `CHK("readback", 32'h87, rd)
      `CHK("mapped err", 1'b0, er)
      apb(1'b1, 12'h380, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      apb(1'b0, CA, 32'h0);
      `CHK("no alias", 32'h87, rd)
      apb(1'b0, 12'h388, 32'h0);
      `CHK("unmapped read", 32'h0, rd)
      `CHK("unmapped read err", 1'b1, er)
      for (int c = 0; c < 8; c++) begin
         arm(32'hC0 | c);
         n = 0;
         while (chip_reset_out !== 1'b1 && n < 900) begin
            @(posedge ref_clk_in);
            n++;
         end
         // a pulse that never came fails here
         `CHK("reset pulse", 1'b1, chip_reset_out)
         `CHK("ticks to reset", PD * UT * ((c == 0) ? 8 : c), ticks)
         repeat (20) @(posedge ref_clk_in);
         apb(1'b0, CA, 32'h0);
         `CHK("after timeout", 32'h0, rd)
      end
      arm(32'hC1);
      for (int k = 1; k < 4; k++) begin
         till(3 * k);
         apb(1'b1, CA, 32'hC1);
      end
      till(11);
      `CHK("serviced", 1'b0, seen)
      arm(32'hC2);
      till(5);
      apb(1'b1, CA, 32'h02);
      till(25);
      `CHK("disabled", 1'b0, seen)
      apb(1'b1, CA, 32'h82);
      repeat (48) @(posedge ref_clk_in);
      `CHK("count kept", 1'b1, seen)
      give_verdict();
   end
endmodule
